/* File: shared/sysconf_pkg.sv */
// system configuration block: register map, field layout, unlock keys, bus carriers.
// assumes a 24-bit byte address on an AXI4-Lite slave port with 32-bit data.
package sysconf_pkg;

	localparam int          ADDR_W             = 24;
	localparam int          ENV_W              = 3;

	// register byte addresses
	localparam logic [23:0] CFG_ADDR           = 24'hFFF910;
	localparam logic [23:0] STAT_ADDR          = 24'hFFF914;
	localparam logic [23:0] SWRST_ADDR         = 24'hFFF918;

	// configuration register fields
	localparam int          CFG_IOZONE_BIT     = 0;
	localparam int          CFG_PLL_BIT        = 1;
	localparam int          CFG_SLOW_BIT       = 3;
	localparam int          CFG_XCVR_BIT       = 4;
	localparam int          CFG_MISC_SLEW_BIT  = 5;
	localparam int          CFG_MEM_SLEW_BIT   = 6;
	localparam logic [7:0]  CFG_RST            = 8'h10;
	localparam logic [7:0]  CFG_WMASK          = 8'h7F;

	// status register fields
	localparam int          STAT_WDOG_BIT      = 6;

	// software reset keys
	localparam logic [7:0]  KEY_UNLOCK         = 8'hE1;
	localparam logic [7:0]  KEY_ENTER          = 8'h3E;
	localparam logic [7:0]  KEY_LEAVE          = 8'h0E;
	localparam logic [3:0]  BOOT_UNDEFINED     = 4'hF;
	localparam logic [6:0]  UNLOCK_WINDOW      = 7'h7F;
	// edges after power-on release until the pins are captured, one past the two edges the pin synchroniser needs to hold real levels
	localparam logic [1:0]  CAPTURE_WAIT       = 2'h3;

	localparam logic [1:0]  RESP_OKAY          = 2'h0;
	localparam logic [1:0]  RESP_SLVERR        = 2'h2;

	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'h0,
		SEQ_ARMED   = 2'h1,
		SEQ_PENDING = 2'h3
	} seq_e;

	typedef enum logic [1:0] {
		SEL_CFG   = 2'h0,
		SEL_STAT  = 2'h1,
		SEL_SWRST = 2'h2,
		SEL_NONE  = 2'h3
	} reg_sel_e;

	typedef struct packed {
		logic [23:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [23:0] araddr;
		logic        arvalid;
		logic        rready;
	} axil_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_s;

	typedef struct packed {
		logic [2:0] env_out;
		logic [2:0] env_oe_n;
		logic       misc_slow;
		logic       mem_slow;
	} pad_s;

	typedef struct packed {
		logic       internal_rom_environment;
		logic       external_rom_environment;
		logic [3:0] boot_region_size_field;
		logic       programming_code_present;
	} boot_cond_s;

endpackage

/* File: rtl/env_pin_sync.sv */
// two-stage synchroniser for the three environment pins.
// assumes the pins change asynchronously to aclk.
`timescale 1ns/100ps
module env_pin_sync (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [sysconf_pkg::ENV_W-1:0] pins,
	output logic      [sysconf_pkg::ENV_W-1:0] pins_sync
);
	typedef struct packed {
		logic [sysconf_pkg::ENV_W-1:0] meta;
		logic [sysconf_pkg::ENV_W-1:0] stable;
	} sync_s;

	sync_s s_r;
	sync_s s_nxt;

	always_comb begin
		s_nxt        = s_r;
		s_nxt.meta   = pins;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pins_sync = s_r.stable;
endmodule

/* File: rtl/system_config.sv */
// system configuration and software reset block behind an AXI4-Lite slave.
// assumes aresetn is the power-on reset; external and watchdog resets arrive
// as one-cycle pulses from the reset logic on aclk.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps

module system_config (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire sysconf_pkg::axil_req_s  axi_req,
	output sysconf_pkg::axil_rsp_s       axi_rsp,
	input  wire sysconf_pkg::boot_cond_s boot_cond,
	input  wire logic                    external_reset,
	input  wire logic                    watchdog_reset,
	input  wire logic                    power_mode_active,
	input  wire logic [2:0]              environment_pins,
	input  wire logic                    any_flash_busy,
	input  wire logic                    data_flash_busy,
	input  wire logic                    flash_interface_busy,
	input  wire logic                    usb_controller_suspend,
	input  wire logic                    function_word_usb_enable,
	input  wire logic                    pll_clock,
	input  wire logic                    main_clock,
	input  wire logic                    slow_clock,
	output sysconf_pkg::pad_s            pads,
	output logic                         io_zone_external_bus_on,
	output logic                         transceiver_low_power,
	output logic                         system_reset_request,
	output logic                         boot_into_programming
);
	typedef struct packed {
		logic [7:0]             cfg;
		logic [2:0]             env_cap;
		logic [1:0]             cap_wait;
		logic                   wdog_flag;
		logic                   prog_flag;
		logic                   sticky_prog;
		sysconf_pkg::seq_e      seq;
		logic                   seq_enter;
		logic [6:0]             cnt;
		logic                   rst_req;
		logic                   any_busy;
		logic                   data_busy;
		logic                   aw_got;
		logic                   w_got;
		logic [23:0]            awaddr;
		logic [7:0]             wdata;
		logic                   wstrb0;
		sysconf_pkg::axil_rsp_s rsp;
		sysconf_pkg::pad_s      pad;
		logic                   iozone;
		logic                   xcvr_lp;
	} state_s;

	localparam state_s STATE_RST = '{
		cfg:         sysconf_pkg::CFG_RST,
		env_cap:     3'h0,
		cap_wait:    sysconf_pkg::CAPTURE_WAIT,
		wdog_flag:   1'b0,
		prog_flag:   1'b0,
		sticky_prog: 1'b0,
		seq:         sysconf_pkg::SEQ_IDLE,
		seq_enter:   1'b0,
		cnt:         7'h00,
		rst_req:     1'b0,
		any_busy:    1'b0,
		data_busy:   1'b0,
		aw_got:      1'b0,
		w_got:       1'b0,
		awaddr:      24'h000000,
		wdata:       8'h00,
		wstrb0:      1'b0,
		rsp:         '{default: 1'b0},
		pad:         '{env_out: 3'h0, env_oe_n: 3'h7, misc_slow: 1'b0, mem_slow: 1'b0},
		iozone:      1'b0,
		xcvr_lp:     1'b1
	};

	state_s     s_r;
	state_s     s_nxt;
	logic [2:0] env_sync;

	env_pin_sync u_env_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pins      (environment_pins),
		.pins_sync (env_sync)
	);

	function automatic sysconf_pkg::reg_sel_e reg_select(input logic [23:0] addr);
		logic [23:0] word;
		word = {addr[23:2], 2'h0};
		if (word == sysconf_pkg::CFG_ADDR) begin
			return sysconf_pkg::SEL_CFG;
		end else if (word == sysconf_pkg::STAT_ADDR) begin
			return sysconf_pkg::SEL_STAT;
		end else if (word == sysconf_pkg::SWRST_ADDR) begin
			return sysconf_pkg::SEL_SWRST;
		end else begin
			return sysconf_pkg::SEL_NONE;
		end
	endfunction

	logic       aw_hs;
	logic       w_hs;
	logic       ar_hs;
	logic       do_write;
	logic       key_in;
	logic       enter_ok;
	logic       warm_reset;
	logic [7:0] status;

	always_comb begin
		s_nxt      = s_r;
		aw_hs      = axi_req.awvalid & s_r.rsp.awready;
		w_hs       = axi_req.wvalid & s_r.rsp.wready;
		ar_hs      = axi_req.arvalid & s_r.rsp.arready;
		do_write   = s_r.aw_got & s_r.w_got & ~s_r.rsp.bvalid;
		key_in     = 1'b0;
		s_nxt.rst_req = 1'b0;
		status     = {s_r.prog_flag, s_r.wdog_flag, 1'b0, s_r.data_busy,
			s_r.any_busy, s_r.env_cap};
		enter_ok   = (boot_cond.internal_rom_environment | boot_cond.external_rom_environment)
			& (boot_cond.boot_region_size_field != sysconf_pkg::BOOT_UNDEFINED)
			& boot_cond.programming_code_present;

		// flash busy flags come from logic on aclk, so one register stage suffices
		s_nxt.any_busy  = any_flash_busy;
		s_nxt.data_busy = data_flash_busy;

		// the synchroniser is reset with us, so wait until it carries the pins
		if (s_r.cap_wait != 2'h0) begin
			if (s_r.cap_wait == 2'h1) begin
				s_nxt.env_cap = env_sync;
			end
			s_nxt.cap_wait = s_r.cap_wait - 2'h1;
		end

		// write address and data may arrive in either order
		if (aw_hs) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = axi_req.awaddr;
		end
		if (w_hs) begin
			s_nxt.w_got  = 1'b1;
			s_nxt.wdata  = axi_req.wdata[7:0];
			s_nxt.wstrb0 = axi_req.wstrb[0];
		end
		if (do_write) begin
			s_nxt.aw_got     = 1'b0;
			s_nxt.w_got      = 1'b0;
			s_nxt.rsp.bvalid = 1'b1;
			s_nxt.rsp.bresp  = sysconf_pkg::RESP_OKAY;
			case (reg_select(s_r.awaddr))
				sysconf_pkg::SEL_CFG: begin
					// writes outside active mode are dropped so a sleeping core
					// cannot leave the pads half configured
					if (s_r.wstrb0 && power_mode_active) begin
						s_nxt.cfg = s_r.wdata & sysconf_pkg::CFG_WMASK;
					end
				end
				sysconf_pkg::SEL_STAT: begin
					if (s_r.wstrb0 && s_r.wdata[sysconf_pkg::STAT_WDOG_BIT]) begin
						s_nxt.wdog_flag = 1'b0;
					end
				end
				sysconf_pkg::SEL_SWRST: begin
					key_in = s_r.wstrb0;
				end
				default: begin
					s_nxt.rsp.bresp = sysconf_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_r.rsp.bvalid && axi_req.bready) begin
			s_nxt.rsp.bvalid = 1'b0;
		end

		if (ar_hs) begin
			s_nxt.rsp.rvalid = 1'b1;
			s_nxt.rsp.rresp  = sysconf_pkg::RESP_OKAY;
			case (reg_select(axi_req.araddr))
				sysconf_pkg::SEL_CFG: begin
					s_nxt.rsp.rdata = {24'h000000, s_r.cfg};
				end
				sysconf_pkg::SEL_STAT: begin
					s_nxt.rsp.rdata = {24'h000000, status};
				end
				sysconf_pkg::SEL_SWRST: begin
					// write-only: reads as zero
					s_nxt.rsp.rdata = 32'h00000000;
				end
				default: begin
					s_nxt.rsp.rdata = 32'h00000000;
					s_nxt.rsp.rresp = sysconf_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_r.rsp.rvalid && axi_req.rready) begin
			s_nxt.rsp.rvalid = 1'b0;
		end

		// cleared before the sequence so a coinciding programming entry is kept
		if (external_reset) begin
			s_nxt.wdog_flag = 1'b0;
			s_nxt.prog_flag = 1'b0;
		end

		// unlock sequence
		case (s_r.seq)
			sysconf_pkg::SEQ_IDLE: begin
				if (key_in && s_r.wdata == sysconf_pkg::KEY_UNLOCK) begin
					s_nxt.seq = sysconf_pkg::SEQ_ARMED;
					s_nxt.cnt = 7'h00;
				end
			end
			sysconf_pkg::SEQ_ARMED: begin
				if (key_in) begin
					if (s_r.wdata == sysconf_pkg::KEY_ENTER && enter_ok) begin
						s_nxt.seq       = sysconf_pkg::SEQ_PENDING;
						s_nxt.seq_enter = 1'b1;
					end else if (s_r.wdata == sysconf_pkg::KEY_LEAVE) begin
						s_nxt.seq       = sysconf_pkg::SEQ_PENDING;
						s_nxt.seq_enter = 1'b0;
					end else begin
						s_nxt.seq = sysconf_pkg::SEQ_IDLE;
					end
				end else if (s_r.cnt == sysconf_pkg::UNLOCK_WINDOW - 7'h01) begin
					s_nxt.seq = sysconf_pkg::SEQ_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt + 7'h01;
				end
			end
			sysconf_pkg::SEQ_PENDING: begin
				// an erase cut short by reset would leave flash corrupted
				if (!flash_interface_busy) begin
					s_nxt.rst_req = 1'b1;
					s_nxt.seq     = sysconf_pkg::SEQ_IDLE;
					if (s_r.seq_enter) begin
						s_nxt.sticky_prog = 1'b1;
						s_nxt.prog_flag   = 1'b1;
					end else begin
						s_nxt.sticky_prog = 1'b0;
						s_nxt.prog_flag   = 1'b0;
					end
				end
			end
			default: begin
				s_nxt.seq = sysconf_pkg::SEQ_IDLE;
			end
		endcase

		// warm resets reload config and recapture the pins; bus state is kept
		warm_reset = external_reset | watchdog_reset | s_r.rst_req;
		if (warm_reset) begin
			s_nxt.cfg      = sysconf_pkg::CFG_RST;
			s_nxt.cap_wait = 2'h1;
			s_nxt.seq      = sysconf_pkg::SEQ_IDLE;
		end
		// set after every clear so a coinciding watchdog event is kept
		if (watchdog_reset) begin
			s_nxt.wdog_flag = 1'b1;
		end

		s_nxt.rsp.awready = ~s_nxt.aw_got & ~s_nxt.rsp.bvalid;
		s_nxt.rsp.wready  = ~s_nxt.w_got & ~s_nxt.rsp.bvalid;
		s_nxt.rsp.arready = ~s_nxt.rsp.rvalid;

		s_nxt.iozone = s_r.cfg[sysconf_pkg::CFG_IOZONE_BIT]
			& boot_cond.internal_rom_environment;
		s_nxt.pad.env_out  = {slow_clock, main_clock, pll_clock};
		s_nxt.pad.env_oe_n = ~s_r.cfg[sysconf_pkg::CFG_SLOW_BIT:sysconf_pkg::CFG_PLL_BIT];
		s_nxt.pad.misc_slow = s_r.cfg[sysconf_pkg::CFG_MISC_SLEW_BIT];
		s_nxt.pad.mem_slow  = s_r.cfg[sysconf_pkg::CFG_MEM_SLEW_BIT];
		s_nxt.xcvr_lp = ~s_r.cfg[sysconf_pkg::CFG_XCVR_BIT] | usb_controller_suspend
			| ~function_word_usb_enable;
	end

	// share the env_oe_n slice above, one bit per pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign axi_rsp                 = s_r.rsp;
	assign pads                    = s_r.pad;
	assign io_zone_external_bus_on = s_r.iozone;
	assign transceiver_low_power   = s_r.xcvr_lp;
	assign system_reset_request    = s_r.rst_req;
	assign boot_into_programming   = s_r.sticky_prog;
endmodule

/* File: verification/system_config_properties.sv */
// property checker for system_config, bound onto every instance.
// assumes one aclk domain with aresetn synchronous and active low.
`timescale 1ns/100ps
module system_config_properties (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire sysconf_pkg::boot_cond_s boot_cond,
	input wire logic                    pll_clock,
	input wire logic                    usb_controller_suspend,
	input wire logic                    function_word_usb_enable,
	input wire logic                    flash_interface_busy,
	input wire sysconf_pkg::pad_s       pads,
	input wire logic                    io_zone_external_bus_on,
	input wire logic                    transceiver_low_power,
	input wire logic                    system_reset_request,
	input wire logic                    boot_into_programming
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// reset itself is the cause here, so this one must not be disabled by it
	a_reset_pads_idle:
		assert property (disable iff (1'b0) !aresetn |=> pads.env_oe_n == 3'h7 &&
			!pads.misc_slow && !pads.mem_slow && !io_zone_external_bus_on)
		else $error("pads or io zone not idle after reset");
	a_iozone_needs_rom:
		assert property (io_zone_external_bus_on |-> $past(boot_cond.internal_rom_environment))
		else $error("io zone bus on outside internal rom environment");
	a_pll_pin_clock:
		assert property (!pads.env_oe_n[0] |-> pads.env_out[0] == $past(pll_clock))
		else $error("pll clock not driven on pin 0");
	a_xcvr_forced_low:
		assert property ((usb_controller_suspend || !function_word_usb_enable)
			|=> transceiver_low_power)
		else $error("transceiver not in low power");
	a_entry_needs_cond:
		assert property ($rose(boot_into_programming) |-> system_reset_request &&
			(boot_cond.internal_rom_environment || boot_cond.external_rom_environment) &&
			boot_cond.programming_code_present &&
			boot_cond.boot_region_size_field != sysconf_pkg::BOOT_UNDEFINED)
		else $error("programming entry without its conditions");
	a_reset_one_cycle:
		assert property (system_reset_request |=> !system_reset_request)
		else $error("software reset pulse longer than one cycle");
	a_entry_sticky:
		assert property ($fell(boot_into_programming) |-> system_reset_request)
		else $error("programming entry dropped without software reset");
	a_reset_waits_flash:
		assert property (flash_interface_busy |=> !system_reset_request)
		else $error("software reset issued while flash busy");

	c_entry: cover property (system_reset_request && boot_into_programming);
	c_leave: cover property ($fell(boot_into_programming));
	c_pins: cover property (io_zone_external_bus_on && !pads.env_oe_n[0]);
endmodule

bind system_config system_config_properties u_props (
	.aclk, .aresetn, .boot_cond, .pll_clock, .usb_controller_suspend,
	.function_word_usb_enable, .flash_interface_busy, .pads, .io_zone_external_bus_on,
	.transceiver_low_power, .system_reset_request, .boot_into_programming
);

/* File: verification/system_config_bench.sv */
// self-checking bench for system_config; drives every port from here.
// assumes the property checker comes in through its bind file.
`timescale 1ns/100ps
module system_config_bench;
	logic                    aclk        = 1'b0;
	logic                    aresetn     = 1'b0;
	sysconf_pkg::axil_req_s  rq          = '0;
	sysconf_pkg::axil_rsp_s  rs;
	sysconf_pkg::boot_cond_s bc          = 7'h41;
	sysconf_pkg::pad_s       pads;
	logic                    ext_rst     = 1'b0;
	logic                    wd_rst      = 1'b0;
	logic                    pm_act      = 1'b1;
	logic [2:0]              env         = 3'h5;
	logic                    afb         = 1'b0;
	logic                    dfb         = 1'b0;
	logic                    fib         = 1'b0;
	logic                    usp         = 1'b0;
	logic                    fwe         = 1'b1;
	logic [2:0]              clks        = 3'h0;
	logic                    ioz;
	logic                    xlp;
	logic                    srq;
	logic                    bip;
	int                      n_mismatch  = 0;
	int                      comparisons = 0;
	int                      cyc         = 0;

	system_config u_dut (
		.aclk, .aresetn, .axi_req(rq), .axi_rsp(rs), .boot_cond(bc),
		.external_reset(ext_rst), .watchdog_reset(wd_rst), .power_mode_active(pm_act),
		.environment_pins(env), .any_flash_busy(afb), .data_flash_busy(dfb),
		.flash_interface_busy(fib), .usb_controller_suspend(usp),
		.function_word_usb_enable(fwe), .pll_clock(clks[0]), .main_clock(clks[1]),
		.slow_clock(clks[2]), .pads, .io_zone_external_bus_on(ioz),
		.transceiver_low_power(xlp), .system_reset_request(srq), .boot_into_programming(bip)
	);

	always #5 aclk = ~aclk;
	// pin clocks toggle at different rates so a swapped pin shows up
	always @(posedge aclk) clks <= clks + 3'h1;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic final_report;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (comparisons > 0 && n_mismatch == 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask

	task automatic wr(input logic [23:0] a, input logic [7:0] d,
		input logic [1:0] r = sysconf_pkg::RESP_OKAY);
		@(posedge aclk);
		rq.awaddr <= a;
		rq.wdata <= {24'h000000, d};
		rq.wstrb <= 4'hF;
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rs.awready === 1'b1) rq.awvalid <= 1'b0;
			if (rs.wready === 1'b1) rq.wvalid <= 1'b0;
		end while (rs.bvalid !== 1'b1);
		rq.bready <= 1'b0;
		chk(rs.bresp, r);
	endtask

	task automatic rd(input logic [23:0] a, input logic [7:0] d,
		input logic [1:0] r = sysconf_pkg::RESP_OKAY);
		@(posedge aclk);
		rq.araddr <= a;
		rq.arvalid <= 1'b1;
		rq.rready <= 1'b1;
		do @(posedge aclk); while (rs.arready !== 1'b1);
		rq.arvalid <= 1'b0;
		do @(posedge aclk); while (rs.rvalid !== 1'b1);
		rq.rready <= 1'b0;
		chk(rs.rdata, {24'h000000, d});
		chk(rs.rresp, r);
	endtask

	task automatic warm(input logic wd);
		@(posedge aclk);
		if (wd) wd_rst <= 1'b1;
		else ext_rst <= 1'b1;
		@(posedge aclk);
		wd_rst <= 1'b0;
		ext_rst <= 1'b0;
		settle(4);
	endtask

	// the pulse may land in the write's own closing cycle, so look before the edge
	task automatic catch_req(input logic ex);
		logic p;
		p = 1'b0;
		repeat (20) begin
			#1;
			if (srq === 1'b1) p = 1'b1;
			@(posedge aclk);
		end
		chk(p, ex);
	endtask

	task automatic seq(input logic [7:0] k, input int gap, input logic ex);
		wr(sysconf_pkg::SWRST_ADDR, sysconf_pkg::KEY_UNLOCK);
		repeat (gap) @(posedge aclk);
		wr(sysconf_pkg::SWRST_ADDR, k);
		catch_req(ex);
	endtask

	task automatic t_reset;
		settle(1);
		chk({pads.env_oe_n, xlp}, 4'hE);
		rd(sysconf_pkg::CFG_ADDR, 8'h10);
		rd(sysconf_pkg::STAT_ADDR, 8'h05);
	endtask

	task automatic t_cfg;
		wr(sysconf_pkg::CFG_ADDR, 8'h7F);
		settle(2);
		chk({pads.env_oe_n, pads.misc_slow, pads.mem_slow, ioz, xlp}, 7'h0E);
		chk(pads.env_out, 3'(clks - 3'h1));
		rd(sysconf_pkg::CFG_ADDR, 8'h7F);
		@(posedge aclk) bc.internal_rom_environment <= 1'b0;
		@(posedge aclk) usp <= 1'b1;
		settle(2);
		chk({ioz, xlp}, 2'h1);
		@(posedge aclk);
		bc.internal_rom_environment <= 1'b1;
		usp <= 1'b0;
		wr(sysconf_pkg::CFG_ADDR, 8'h2A);
		settle(2);
		chk({pads.env_oe_n, pads.misc_slow, pads.mem_slow, ioz, xlp}, 7'h29);
		@(posedge aclk) pm_act <= 1'b0;
		wr(sysconf_pkg::CFG_ADDR, 8'h7F);
		rd(sysconf_pkg::CFG_ADDR, 8'h2A);
		@(posedge aclk) pm_act <= 1'b1;
		@(posedge aclk) env <= 3'h2;
		wr(24'hFFF91C, 8'h7F, sysconf_pkg::RESP_SLVERR);
		rd(24'hFFF91C, 8'h00, sysconf_pkg::RESP_SLVERR);
		rd(sysconf_pkg::SWRST_ADDR, 8'h00);
		rd(sysconf_pkg::STAT_ADDR, 8'h05);
	endtask

	task automatic t_status;
		@(posedge aclk) afb <= 1'b1;
		rd(sysconf_pkg::STAT_ADDR, 8'h0D);
		@(posedge aclk);
		afb <= 1'b0;
		dfb <= 1'b1;
		rd(sysconf_pkg::STAT_ADDR, 8'h15);
		@(posedge aclk) dfb <= 1'b0;
		rd(sysconf_pkg::STAT_ADDR, 8'h05);
		wr(sysconf_pkg::CFG_ADDR, 8'h7F);
		warm(1'b1);
		rd(sysconf_pkg::CFG_ADDR, 8'h10);
		rd(sysconf_pkg::STAT_ADDR, 8'h42);
		wr(sysconf_pkg::STAT_ADDR, 8'h40);
		rd(sysconf_pkg::STAT_ADDR, 8'h02);
		warm(1'b1);
		warm(1'b0);
		rd(sysconf_pkg::STAT_ADDR, 8'h02);
	endtask

	task automatic t_swrst;
		@(posedge aclk) fib <= 1'b1;
		seq(sysconf_pkg::KEY_ENTER, 0, 1'b0);
		@(posedge aclk) fib <= 1'b0;
		catch_req(1'b1);
		chk(bip, 1'b1);
		rd(sysconf_pkg::STAT_ADDR, 8'h82);
		warm(1'b0);
		chk(bip, 1'b1);
		rd(sysconf_pkg::STAT_ADDR, 8'h02);
		seq(sysconf_pkg::KEY_LEAVE, 0, 1'b1);
		chk(bip, 1'b0);
		@(posedge aclk) bc.boot_region_size_field <= sysconf_pkg::BOOT_UNDEFINED;
		seq(sysconf_pkg::KEY_ENTER, 0, 1'b0);
		@(posedge aclk) bc.boot_region_size_field <= 4'h0;
		seq(8'h55, 0, 1'b0);
		seq(sysconf_pkg::KEY_LEAVE, 124, 1'b0);
		seq(sysconf_pkg::KEY_LEAVE, 123, 1'b1);
		seq(sysconf_pkg::KEY_ENTER, 0, 1'b1);
		chk(bip, 1'b1);
	endtask

	// power-on reset in mid-run drops sticky programming entry
	task automatic t_por;
		@(posedge aclk) aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		settle(1);
		chk({bip, srq, pads.env_oe_n, xlp}, 6'h0E);
		rd(sysconf_pkg::CFG_ADDR, 8'h10);
		rd(sysconf_pkg::STAT_ADDR, 8'h02);
	endtask

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_cfg();
		t_status();
		t_swrst();
		t_por();
		final_report();
	end
endmodule
